// ---- design/timer_channel.sv ----
// Purpose: one channel of the interval timer: square wave and strobe modes.
// Assumes: tclk and gate are synchronous to mclk and far slower than it.
// Notes:   count moves only in the mclk cycle that sees tclk fall; output also on control writes and square wave gate fall.
`timescale 1ns/1ps
`default_nettype none

module timer_channel #(
   parameter int CHANNEL = 2
) (
   input  wire logic                     mclk,
   input  wire logic                     rst_n,
   input  wire timer_pkg::host_write_type host,
   input  wire logic                     tclk,
   input  wire logic                     gate,
   output logic                          out,
   output logic [15:0]                   count_value
);

   // ***********************************************
   // elaboration check
   // ***********************************************
   generate
      if (CHANNEL != 0 && CHANNEL != 2 && CHANNEL != 3) begin : bad_channel
         $error("timer_channel: CHANNEL must be 0, 2 or 3");
      end
   endgenerate

   // ***********************************************
   // declarations
   // ***********************************************
   logic                 tclk_q;
   logic                 gate_q;
   logic                 gate_s;
   logic                 trig_pend;
   logic [15:0]          cr;
   logic                 byte_hi;
   timer_pkg::mode_type  mode;
   logic [1:0]           rw;
   logic                 bcd;
   logic                 dbl;
   logic                 count_full;
   timer_pkg::run_type   st;
   logic [15:0]          ce;
   logic                 load_pend;
   logic                 odd_hold;
   logic                 pulse_rise;
   logic                 pulse_fall;
   logic                 gate_fell;
   logic                 ctrl_ok;
   timer_pkg::mode_type  next_mode;
   logic [2:0]           step;
   logic [15:0]          stepped;
   logic [15:0]          reload;

   assign pulse_rise = tclk & ~tclk_q;
   assign pulse_fall = ~tclk & tclk_q;
   assign gate_fell  = ~gate & gate_q;
   // a latch command carries rw 00; it belongs elsewhere and must not reset us
   assign ctrl_ok    = host.ctrl_wr && host.data[timer_pkg::CTRL_RW_MSB:timer_pkg::CTRL_RW_LSB]
                       != timer_pkg::RW_LATCH;
   assign next_mode  = timer_pkg::decode_mode(host.data, CHANNEL);
   assign step       = (mode == timer_pkg::MODE_SQUARE) ? timer_pkg::STEP_TWO
                                                        : timer_pkg::STEP_ONE;
   // clearing bit 0 gives N-1 for odd N in binary and decimal alike
   assign reload     = (mode == timer_pkg::MODE_SQUARE) ? {cr[15:1], 1'b0} : cr;

   count_step u_step (
      .value  (ce),
      .bcd    (bcd),
      .step   (step),
      .result (stepped)
   );

   // ***********************************************
   // clock pulse and gate sampling
   // ***********************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tclk_q    <= 1'b0;
         gate_q    <= 1'b0;
         // high so that a gate idling high gives no false trigger after reset
         gate_s    <= 1'b1;
         trig_pend <= 1'b0;
      end else begin
         tclk_q <= tclk;
         gate_q <= gate;
         if (pulse_rise) begin
            gate_s <= gate;
         end
         if (ctrl_ok) begin
            trig_pend <= 1'b0;
         end else if (pulse_rise && gate && !gate_s) begin
            trig_pend <= 1'b1;
         end else if (pulse_fall) begin
            trig_pend <= 1'b0;
         end
      end
   end

   // ***********************************************
   // host writes
   // ***********************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cr         <= timer_pkg::COUNT_RESET;
         byte_hi    <= 1'b0;
         mode       <= timer_pkg::MODE_OFF;
         rw         <= timer_pkg::RW_LOW;
         bcd        <= 1'b0;
         dbl        <= 1'b0;
         count_full <= 1'b0;
      end else begin
         count_full <= 1'b0;
         if (ctrl_ok) begin
            mode    <= next_mode;
            bcd     <= (CHANNEL == timer_pkg::CHANNEL_BYTE_ONLY) ? 1'b0
                       : host.data[timer_pkg::CTRL_BCD_BIT];
            rw      <= (CHANNEL == timer_pkg::CHANNEL_BYTE_ONLY) ? timer_pkg::RW_LOW
                       : host.data[timer_pkg::CTRL_RW_MSB:timer_pkg::CTRL_RW_LSB];
            byte_hi <= 1'b0;
            dbl     <= (next_mode == timer_pkg::MODE_SQUARE);
         end else if (host.data_wr) begin
            dbl <= 1'b0;
            if (CHANNEL == timer_pkg::CHANNEL_BYTE_ONLY) begin
               cr         <= {8'h00, host.data};
               count_full <= 1'b1;
            end else begin
               case (rw)
                  timer_pkg::RW_LOW: begin
                     cr         <= {8'h00, host.data};
                     count_full <= 1'b1;
                  end
                  timer_pkg::RW_HIGH: begin
                     cr         <= {host.data, 8'h00};
                     count_full <= 1'b1;
                  end
                  default: begin
                     // low byte first; only the high byte completes the count
                     if (byte_hi) begin
                        cr[15:8]   <= host.data;
                        count_full <= 1'b1;
                     end else begin
                        cr[7:0] <= host.data;
                     end
                     byte_hi <= ~byte_hi;
                  end
               endcase
            end
         end
      end
   end

   // ***********************************************
   // counting element and output
   // ***********************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st          <= timer_pkg::ST_IDLE;
         ce          <= timer_pkg::COUNT_RESET;
         out         <= timer_pkg::OUT_RESET;
         load_pend   <= 1'b0;
         odd_hold    <= 1'b0;
      end else if (ctrl_ok) begin
         st        <= timer_pkg::ST_IDLE;
         load_pend <= 1'b0;
         odd_hold  <= 1'b0;
         // square wave starts low unless the byte came twice in a row
         out       <= (next_mode == timer_pkg::MODE_SQUARE) ? dbl : 1'b1;
      end else begin
         if (count_full) begin
            case (mode)
               timer_pkg::MODE_SQUARE: begin
                  if (st == timer_pkg::ST_IDLE) begin
                     load_pend <= 1'b1;
                  end
               end
               timer_pkg::MODE_SW: begin
                  load_pend <= 1'b1;
               end
               timer_pkg::MODE_HW: begin
                  if (st == timer_pkg::ST_IDLE) begin
                     st <= timer_pkg::ST_ARMED;
                  end
               end
               default: begin
               end
            endcase
         end
         if (mode == timer_pkg::MODE_SQUARE && gate_fell && !out) begin
            out <= 1'b1;
         end else if (pulse_fall) begin
            case (mode)
               timer_pkg::MODE_SQUARE: begin
                  if (load_pend || (trig_pend && st == timer_pkg::ST_RUN)) begin
                     ce        <= reload;
                     st        <= timer_pkg::ST_RUN;
                     load_pend <= 1'b0;
                     odd_hold  <= 1'b0;
                  end else if (st == timer_pkg::ST_RUN && gate_s) begin
                     if (odd_hold) begin
                        out      <= ~out;
                        ce       <= reload;
                        odd_hold <= 1'b0;
                     end else if (stepped == 16'h0000) begin
                        if (cr[0] && out) begin
                           ce       <= 16'h0000;
                           odd_hold <= 1'b1;
                        end else begin
                           out <= ~out;
                           ce  <= reload;
                        end
                     end else begin
                        ce <= stepped;
                     end
                  end
               end
               timer_pkg::MODE_SW: begin
                  if (!out && gate_s) begin
                     out <= 1'b1;
                  end
                  if (load_pend) begin
                     ce        <= cr;
                     st        <= timer_pkg::ST_RUN;
                     load_pend <= 1'b0;
                  end else if (st != timer_pkg::ST_IDLE && gate_s) begin
                     ce <= stepped;
                     if (st == timer_pkg::ST_RUN && stepped == 16'h0000) begin
                        out <= 1'b0;
                        st  <= timer_pkg::ST_WRAP;
                     end
                  end
               end
               timer_pkg::MODE_HW: begin
                  out <= 1'b1;
                  if (trig_pend && st != timer_pkg::ST_IDLE) begin
                     ce <= cr;
                     st <= timer_pkg::ST_RUN;
                  end else if (st == timer_pkg::ST_RUN || st == timer_pkg::ST_WRAP) begin
                     ce <= stepped;
                     if (st == timer_pkg::ST_RUN && stepped == 16'h0000) begin
                        out <= 1'b0;
                        st  <= timer_pkg::ST_WRAP;
                     end
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count_value <= timer_pkg::COUNT_RESET;
      end else begin
         count_value <= ce;
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   function automatic logic digits_ok(input logic [15:0] v);
      digits_ok = v[3:0] <= 4'h9 && v[7:4] <= 4'h9 && v[11:8] <= 4'h9 && v[15:12] <= 4'h9;
   endfunction

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_ctrl_sets_out: assert property (
      ctrl_ok && next_mode != timer_pkg::MODE_SQUARE |=> out && st == timer_pkg::ST_IDLE)
      else $error("control byte did not reset channel");

   a_count_on_fall: assert property (
      $changed(ce) |-> $past(pulse_fall))
      else $error("count moved outside clock pulse fall");

   a_gate_on_rise: assert property (
      $changed(gate_s) |-> $past(pulse_rise))
      else $error("gate sampled outside clock pulse rise");

   a_gate_forces_high: assert property (
      mode == timer_pkg::MODE_SQUARE && gate_fell && !out && !ctrl_ok |=> out)
      else $error("gate fall did not force output high");

   a_square_stalls: assert property (
      mode == timer_pkg::MODE_SQUARE && st == timer_pkg::ST_RUN && !gate_s && !load_pend
      && !trig_pend && !ctrl_ok |=> $stable(ce))
      else $error("square wave counted with gate low");

   a_strobe_hold: assert property (
      mode == timer_pkg::MODE_SW && !out && !gate_s && !ctrl_ok && !gate_fell
      ##1 !pulse_rise |-> !out)
      else $error("strobe released while gate low");

   a_hw_only_ch2: assert property (
      mode == timer_pkg::MODE_HW |-> CHANNEL == timer_pkg::CHANNEL_HW_STROBE)
      else $error("hardware strobe on wrong channel");

   a_ch3_byte: assert property (
      CHANNEL == timer_pkg::CHANNEL_BYTE_ONLY |-> cr[15:8] == 8'h00)
      else $error("channel 3 count above one byte");

   a_hw_trig_load: assert property (
      mode == timer_pkg::MODE_HW && pulse_fall && trig_pend && st != timer_pkg::ST_IDLE
      && !ctrl_ok && !count_full |=> ce == $past(cr) && st == timer_pkg::ST_RUN)
      else $error("trigger did not load count");

   a_sw_write_loads: assert property (
      mode == timer_pkg::MODE_SW && count_full && !ctrl_ok |=> load_pend || $past(pulse_fall))
      else $error("software retrigger not pending");

   a_bcd_valid: assert property (
      bcd && pulse_fall && digits_ok(ce) && digits_ok(cr) && !ctrl_ok |=> digits_ok(ce))
      else $error("decimal count left valid digits");

endmodule

`default_nettype wire

// ---- include/timer_pkg.sv ----
// Purpose: constants and types shared by the interval timer channel files.
// Assumes: control and count bytes arrive as one-cycle write strobes on mclk.
// Notes:   mode field values are the control byte encodings, don't-care bits zero.
//
// How it works
// - square wave counts only while gate is high; period is N clock pulses.
// - square wave loads on the clock pulse after control byte and count.
// - square wave output low and gate falls: output goes high at once.
// - new square wave count waits for half-cycle end unless a trigger comes.
// - even square count: output high, load N, step by 2, toggle at zero.
// - odd square count: load N-1, high (N+1)/2 pulses, low (N-1)/2 pulses.
// - square wave starting low goes high at half count, low at zero.
// - software strobe: load without decrement, zero after N+1 pulses, one-pulse low.
// - gate low around the strobe holds output low until gate returns high.
// - software strobe reloads after the full count; a first byte changes nothing.
// - writing a new count retriggers software strobe, N+1 pulses later.
// - hardware strobe: gate rising edge loads count, strobe N+1 pulses later.
// - hardware strobe takes a new count only at the next trigger.
// - hardware strobe exists only on channel 2.
// - non-latch control byte write resets the channel at once: output high, square wave low unless written twice.
// - counts load and decrement on the clock pulse falling edge.
// - gate is sampled on the clock pulse rising edge.
// - counters continue past zero: strobe modes wrap, square wave reloads.
// - channel 3 holds only an 8-bit count of mode 0.
// - trigger is a gate rising edge; clock pulse is rise then fall.
// - mode field bits 3..1: square x11, software 100, hardware 101.
// - control bit 0 set selects decimal counting, clear selects binary.

package timer_pkg;

   // ***********************************************
   // control byte layout
   // ***********************************************
   localparam int CTRL_BCD_BIT   = 0;
   localparam int CTRL_MODE_LSB  = 1;
   localparam int CTRL_MODE_MSB  = 3;
   localparam int CTRL_RW_LSB    = 4;
   localparam int CTRL_RW_MSB    = 5;

   localparam logic [1:0] RW_LATCH = 2'h0;
   localparam logic [1:0] RW_LOW   = 2'h1;
   localparam logic [1:0] RW_HIGH  = 2'h2;
   localparam logic [1:0] RW_BOTH  = 2'h3;

   localparam logic [2:0] MODE_SQUARE_CODE = 3'h3;
   localparam logic [2:0] MODE_SW_CODE     = 3'h4;
   localparam logic [2:0] MODE_HW_CODE     = 3'h5;

   // ***********************************************
   // channel numbers and reset values
   // ***********************************************
   localparam int CHANNEL_HW_STROBE = 2;
   localparam int CHANNEL_BYTE_ONLY = 3;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic        OUT_RESET   = 1'b1;
   localparam logic [2:0]  STEP_ONE    = 3'h1;
   localparam logic [2:0]  STEP_TWO    = 3'h2;

   typedef enum logic [1:0] {
      MODE_OFF    = 2'b00,
      MODE_SQUARE = 2'b01,
      MODE_SW     = 2'b10,
      MODE_HW     = 2'b11
   } mode_type;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_RUN   = 2'b10,
      ST_WRAP  = 2'b11
   } run_type;

   typedef struct packed {
      logic       ctrl_wr;
      logic       data_wr;
      logic [7:0] data;
   } host_write_type;

   function automatic mode_type decode_mode(input logic [7:0] ctrl, input int channel);
      logic [2:0] code;
      code = ctrl[CTRL_MODE_MSB:CTRL_MODE_LSB];
      if (channel == CHANNEL_BYTE_ONLY) begin
         decode_mode = MODE_OFF;
      end else if (code[1:0] == MODE_SQUARE_CODE[1:0]) begin
         decode_mode = MODE_SQUARE;
      end else if (code == MODE_SW_CODE) begin
         decode_mode = MODE_SW;
      end else if (code == MODE_HW_CODE && channel == CHANNEL_HW_STROBE) begin
         decode_mode = MODE_HW;
      end else begin
         decode_mode = MODE_OFF;
      end
   endfunction

endpackage

// ---- design/count_step.sv ----
// Purpose: one down-count step of 1 or 2, binary or four-digit decimal.
// Assumes: decimal input digits are valid; step is 1 or 2.
// Notes:   purely combinational.
`timescale 1ns/1ps
`default_nettype none

module count_step (
   input  wire logic [15:0] value,
   input  wire logic        bcd,
   input  wire logic [2:0]  step,
   output logic      [15:0] result
);

   logic [4:0]  borrow;
   logic [15:0] dec_val;

   assign borrow[0] = 1'b0;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : digit
         logic [4:0] sub;
         logic [4:0] diff;
         assign sub  = (g == 0) ? {2'h0, step} : {4'h0, borrow[g]};
         assign diff = {1'b0, value[4*g+3:4*g]} - sub;
         // a negative digit borrows from the next and wraps by adding ten
         assign borrow[g+1]       = diff[4];
         assign dec_val[4*g+3:4*g] = diff[4] ? diff[3:0] + 4'ha : diff[3:0];
      end
   endgenerate

   assign result = bcd ? dec_val : value - {13'h0000, step};

endmodule

`default_nettype wire

// ---- bench/host_model.sv ----
// Purpose: processor side of one timer channel: control and count byte writes.
// Assumes: strobes are launched on the falling mclk edge, one cycle wide.
// Notes:   one idle cycle is left between any two writes.
`timescale 1ns/1ps
`default_nettype none

module host_model (
   input  wire logic                      mclk,
   output var  timer_pkg::host_write_type host
);
   initial begin
      host = '0;
   end

   // ************************************************
   // byte writes
   // ************************************************
   task automatic put(input logic is_ctrl, input logic [7:0] value);
      @(negedge mclk);
      host.ctrl_wr = is_ctrl;
      host.data_wr = !is_ctrl;
      host.data = value;
      @(negedge mclk);
      host = '0;
   endtask

   task automatic write_ctrl(input logic [7:0] value);
      put(1'b1, value);
   endtask

   // callers never hand over a count below the mode minimum
   task automatic write_count(input logic [7:0] value);
      put(1'b0, value);
   endtask
endmodule

`default_nettype wire

// ---- bench/programmable_interval_timer_modes_test.sv ----
// Purpose: self-checking bench for the square wave and strobe channel modes.
// Assumes: one channel clock pulse spans 8 mclk cycles, 3 high and 5 low.
// Notes:   outputs are sampled once the low half of a pulse has settled.
`timescale 1ns/1ps
`default_nettype none

module programmable_interval_timer_modes_test;
   logic                      mclk;
   logic                      rst_n;
   logic                      tclk;
   logic                      gate;
   logic                      out;
   logic                      out_ch0;
   logic [15:0]               count_value;
   timer_pkg::host_write_type host;
   int                        failures;
   int                        check_count;
   int                        cycles;
   logic                      samp [0:15];

   host_model i_host (
      .mclk        (mclk),
      .host        (host)
   );

   timer_channel #(.CHANNEL(2)) i_dut (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .host        (host),
      .tclk        (tclk),
      .gate        (gate),
      .out         (out),
      .count_value (count_value)
   );

   timer_channel #(.CHANNEL(0)) i_chan0 (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .host        (host),
      .tclk        (tclk),
      .gate        (gate),
      .out         (out_ch0),
      .count_value ()
   );

   // ************************************************
   // clock, reset and hang guard
   // ************************************************
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         print_verdict();
      end
   end

   // ************************************************
   // shared tasks
   // ************************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // rise then fall; the low half is long enough for loads to land
   task automatic pulse();
      @(negedge mclk);
      tclk = 1'b1;
      repeat (3) @(negedge mclk);
      tclk = 1'b0;
      repeat (4) @(negedge mclk);
   endtask

   task automatic print_verdict();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // ************************************************
   // scenarios
   // ************************************************
   task automatic test_sw_strobe();
      i_host.write_ctrl(8'h18);
      i_host.write_count(8'h02);
      pulse();
      check(count_value, 16'h0002);
      pulse();
      check({15'h0, out}, 16'h0001);
      pulse();
      check({15'h0, out}, 16'h0000);
      i_host.write_ctrl(8'h18);
      repeat (2) @(negedge mclk);
      check({15'h0, out}, 16'h0001);
      i_host.write_count(8'h03);
      pulse();
      pulse();
      i_host.write_count(8'h01);
      pulse();
      check(count_value, 16'h0001);
      check({15'h0, out}, 16'h0001);
      pulse();
      check({15'h0, out}, 16'h0000);
      pulse();
      check({15'h0, out}, 16'h0001);
      check(count_value, 16'hffff);
      i_host.write_count(8'h01);
      pulse();
      pulse();
      check({15'h0, out}, 16'h0000);
      // gate low while the strobe is low keeps it low past its one pulse
      gate = 1'b0;
      repeat (2) pulse();
      check({15'h0, out}, 16'h0000);
      gate = 1'b1;
      pulse();
      check({15'h0, out}, 16'h0001);
      $display("software strobe test done");
   endtask

   task automatic test_decimal();
      i_host.write_ctrl(8'h39);
      i_host.write_count(8'h00);
      pulse();
      i_host.write_count(8'h01);
      pulse();
      check(count_value, 16'h0100);
      pulse();
      check(count_value, 16'h0099);
      // high byte only, then a latch command that must leave counting alone
      i_host.write_ctrl(8'h28);
      i_host.write_count(8'h01);
      pulse();
      check(count_value, 16'h0100);
      i_host.write_ctrl(8'h00);
      pulse();
      check(count_value, 16'h00ff);
      $display("decimal test done");
   endtask

   task automatic test_square(input int n, input logic twice);
      int highs;
      i_host.write_ctrl(8'h16);
      if (twice) i_host.write_ctrl(8'h16);
      repeat (2) @(negedge mclk);
      check({15'h0, out}, {15'h0, twice});
      i_host.write_count(8'(n));
      pulse();
      highs = 0;
      for (int i = 0; i < 2 * n; i++) begin
         pulse();
         samp[i] = out;
      end
      for (int i = 0; i < n; i++) begin
         check({15'h0, samp[i]}, {15'h0, samp[i + n]});
         highs += samp[i];
         if (n % 2 == 0) check({15'h0, samp[i] ^ samp[i + n / 2]}, 16'h0001);
      end
      check(16'(highs), 16'((n + 1) / 2));
      $display("square wave test done, count %0d", n);
   endtask

   task automatic test_square_gate();
      logic [15:0] held;
      for (int i = 0; i < 10 && out !== 1'b0; i++) pulse();
      // one more pulse so the held count differs from the reload value
      pulse();
      check({15'h0, out}, 16'h0000);
      gate = 1'b0;
      repeat (2) @(negedge mclk);
      check({15'h0, out}, 16'h0001);
      held = count_value;
      repeat (3) pulse();
      check(count_value, held);
      gate = 1'b1;
      pulse();
      check(count_value, 16'h0004);
      $display("square wave gate test done");
   endtask

   task automatic test_hw_strobe();
      gate = 1'b0;
      i_host.write_ctrl(8'h1a);
      i_host.write_count(8'h02);
      pulse();
      gate = 1'b1;
      pulse();
      check(count_value, 16'h0002);
      pulse();
      i_host.write_count(8'h05);
      check(count_value, 16'h0001);
      pulse();
      check({15'h0, out}, 16'h0000);
      check({15'h0, out_ch0}, 16'h0001);
      gate = 1'b0;
      pulse();
      check({15'h0, out}, 16'h0001);
      gate = 1'b1;
      pulse();
      check(count_value, 16'h0005);
      $display("hardware strobe test done");
   endtask

   initial begin
      rst_n = 1'b0;
      tclk = 1'b0;
      gate = 1'b1;
      failures = 0;
      check_count = 0;
      cycles = 0;
      repeat (4) @(negedge mclk);
      rst_n = 1'b1;
      check({15'h0, out}, 16'h0001);
      check(count_value, 16'h0000);
      $display("reset test done");
      test_sw_strobe();
      test_decimal();
      test_square(4, 1'b1);
      test_square(5, 1'b1);
      test_square(4, 1'b0);
      test_square_gate();
      test_hw_strobe();
      print_verdict();
   end
endmodule

`default_nettype wire
